// >>> led_map.svh
// Offsets, field positions, reset values and timing counts of the LED driver
`ifndef LED_MAP_SVH
`define LED_MAP_SVH

// ---------------------------------------------------------------
// Bus register offsets (byte addresses)
// ---------------------------------------------------------------
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DIG_LO 8'h08
`define REG_DIG_HI 8'h0c

// ---------------------------------------------------------------
// Control register fields
// ---------------------------------------------------------------
`define CTRL_EXT_SEL 0
`define CTRL_SOFT_RST 1
`define CTRL_OVF_CLR 2

// ---------------------------------------------------------------
// Status register fields
// ---------------------------------------------------------------
`define STAT_SHUTDOWN 0
`define STAT_OVF 1
`define STAT_BUSY 2
`define STAT_LIMIT_LSB 8
`define STAT_DECODE_LSB 16
`define STAT_WORDS_LSB 24

// ---------------------------------------------------------------
// Serial word layout and command addresses
// ---------------------------------------------------------------
`define WORD_BITS 16
`define WADDR_MSB 11
`define WADDR_LSB 8
`define CMD_NOP 4'h0
`define CMD_DIG_FIRST 4'h1
`define CMD_DIG_LAST 4'h8
`define CMD_DECODE 4'h9
`define CMD_LIMIT 4'hb
`define CMD_SHUTDOWN 4'hc
`define CMD_SOFT_RST 4'hf

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_DECODE 8'h00
`define RST_LIMIT 3'h7
`define RST_SHUTDOWN 1'b1

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define CLK_HZ 100000000
`define SCAN_RATE_HZ 800
`define NUM_DIGITS 8
`define SCAN_DIV (`CLK_HZ / (`SCAN_RATE_HZ * `NUM_DIGITS))
`define SCAN_CNT_W 16
`define FIFO_DEPTH 16

`endif

// >>> led_pkg.sv
// Types shared by the LED driver files
`default_nettype none

package led_pkg;

  // Word commit sequencer
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_APPLY = 2'b01,
    ST_CLEAR = 2'b10
  } ctl_state_t;

  // State of the front end apart from the word FIFO
  typedef struct packed {
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic din_s1;
    logic din_s2;
    logic ld_s1;
    logic ld_s2;
    logic ld_d;
    logic ext_s1;
    logic ext_s2;
    logic ext_d;
    logic [15:0] shreg;
    logic dout;
    logic link_rdy;
    logic [15:0] word;
    ctl_state_t state;
    logic [2:0] clr_idx;
    logic [7:0][7:0] mem;
    logic [7:0] decode;
    logic [2:0] limit;
    logic shutdown;
    logic ext_sel;
    logic ovf;
    logic [7:0] words;
    logic [15:0] div;
    logic [2:0] idx;
    logic [7:0] dig;
    logic [7:0] seg;
    logic a_wr;
    logic [7:0] a_addr;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
  } front_st_t;

endpackage

`default_nettype wire

// >>> led_word_fifo.sv
// Word FIFO between serial capture and register commit
`timescale 1ns/1ps
`default_nettype none

module led_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } fifo_st_t;

  fifo_st_t st_ff;
  fifo_st_t nxt_st;
  logic full;
  logic empty;

  // Extra pointer bit tells full from empty
  assign empty = (st_ff.wptr == st_ff.rptr);
  assign full = (st_ff.wptr[AW] != st_ff.rptr[AW]) &&
                (st_ff.wptr[AW-1:0] == st_ff.rptr[AW-1:0]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st_ff.mem[st_ff.rptr[AW-1:0]];

  // Push and pop
  always_comb begin
    nxt_st = st_ff;
    if (in_valid && !full) begin
      nxt_st.mem[st_ff.wptr[AW-1:0]] = in_data;
      nxt_st.wptr = st_ff.wptr + 1'b1;
    end
    if (out_ready && !empty) begin
      nxt_st.rptr = st_ff.rptr + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

`default_nettype wire

// >>> led_driver_serial_frontend.sv
// Serial front end, display memory and scan of the eight-digit LED driver
//
// Notes on behaviour
// RULE_01 - Shift data in on serial clock rise
// RULE_02 - Strobe rise commits shift word to register
// RULE_03 - Cascade output changes on serial clock fall
// RULE_04 - Cascade output is input delayed sixteen bits
// RULE_05 - Cascade output always driven, never floating
// RULE_06 - Shutdown forces all digit lines high
// RULE_07 - Unlit segments drive low
// RULE_08 - 64-bit memory refreshes display autonomously
// RULE_09 - Shutdown keeps memory and settings intact
// RULE_10 - Display blank after power-up until programmed
// RULE_11 - Per digit font decode or raw segments
// RULE_12 - Scan only programmed number of digits
// RULE_13 - Serial soft reset; optional external scan clock
// RULE_14 - Each digit written without touching others
// RULE_15 - Cascade: sixteen bits per device, one strobe
//
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

`include "led_map.svh"

module led_driver_serial_frontend
  import led_pkg::*;
#(
  parameter int SCAN_DIV = `SCAN_DIV,
  parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Serial link pins
  input wire logic serial_clk,
  input wire logic serial_data_in,
  input wire logic latch_strobe,
  output logic serial_data_out,
  output logic link_ready,
  // Optional external scan clock
  input wire logic ext_scan_clk,
  // Display drivers
  output logic [7:0] digit_drive,
  output logic [7:0] segment_drive,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp
);

  // ---------------------------------------------------------------
  // Local types and constants
  // ---------------------------------------------------------------
  localparam logic [`SCAN_CNT_W-1:0] DIV_LAST =
    `SCAN_CNT_W'(SCAN_DIV - 1);

  front_st_t st_ff;
  front_st_t nxt_st;

  logic sclk_rise;
  logic sclk_fall;
  logic ld_rise;
  logic ext_rise;
  logic scan_tick;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [15:0] fifo_out_data;
  logic fifo_out_ready;
  logic a_phase;
  logic [3:0] cmd;
  logic [7:0] cur;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------

  // Numeric font, bit 7 point, bits 6..0 segments a..g
  function automatic logic [7:0] font(input logic [7:0] v);
    logic [6:0] s;
    s = 7'h00;
    case (v[3:0])
      4'h0: s = 7'h7e;
      4'h1: s = 7'h30;
      4'h2: s = 7'h6d;
      4'h3: s = 7'h79;
      4'h4: s = 7'h33;
      4'h5: s = 7'h5b;
      4'h6: s = 7'h5f;
      4'h7: s = 7'h70;
      4'h8: s = 7'h7f;
      4'h9: s = 7'h7b;
      4'ha: s = 7'h01;
      4'hb: s = 7'h4f;
      4'hc: s = 7'h37;
      4'hd: s = 7'h0e;
      4'he: s = 7'h67;
      default: s = 7'h00;
    endcase
    return {v[7], s};
  endfunction

  // Read mux for the register window
  function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                         input front_st_t s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      `REG_CTRL: r[`CTRL_EXT_SEL] = s.ext_sel;
      `REG_STATUS: begin
        r[`STAT_SHUTDOWN] = s.shutdown;
        r[`STAT_OVF] = s.ovf;
        r[`STAT_BUSY] = (s.state != ST_IDLE);
        r[`STAT_LIMIT_LSB +: 3] = s.limit;
        r[`STAT_DECODE_LSB +: 8] = s.decode;
        r[`STAT_WORDS_LSB +: 8] = s.words;
      end
      `REG_DIG_LO: r = {s.mem[3], s.mem[2], s.mem[1], s.mem[0]};
      `REG_DIG_HI: r = {s.mem[7], s.mem[6], s.mem[5], s.mem[4]};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Edge detection on synchronised pins
  // ---------------------------------------------------------------

  // Edges seen only on the second stage, never the first
  assign sclk_rise = st_ff.sclk_s2 && !st_ff.sclk_d;
  assign sclk_fall = !st_ff.sclk_s2 && st_ff.sclk_d;
  assign ld_rise = st_ff.ld_s2 && !st_ff.ld_d;
  assign ext_rise = st_ff.ext_s2 && !st_ff.ext_d;

  // Scan step from internal divider or external clock
  assign scan_tick = st_ff.ext_sel ? ext_rise : (st_ff.div == DIV_LAST);

  assign a_phase = hsel && htrans[1] && hready;
  assign fifo_out_ready = (st_ff.state == ST_IDLE);
  assign cmd = st_ff.word[`WADDR_MSB:`WADDR_LSB];
  assign cur = st_ff.mem[st_ff.idx];

  // ---------------------------------------------------------------
  // Latched words wait here while a clear or commit is in progress
  // ---------------------------------------------------------------
  // Sixteen words let a host keep streaming a display refresh
  // while a soft reset clear holds the commit sequencer
  led_word_fifo #(
    .WIDTH(`WORD_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .in_valid(ld_rise),
    .in_ready(fifo_in_ready),
    .in_data(st_ff.shreg),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Two-stage synchronisers for every link pin and the external scan clock
    // The link clock is only sampled, so each of its phases must
    // last more than one system clock or its edges can be lost
    nxt_st.sclk_s1 = serial_clk;
    nxt_st.sclk_s2 = st_ff.sclk_s1;
    nxt_st.sclk_d = st_ff.sclk_s2;
    nxt_st.din_s1 = serial_data_in;
    nxt_st.din_s2 = st_ff.din_s1;
    nxt_st.ld_s1 = latch_strobe;
    nxt_st.ld_s2 = st_ff.ld_s1;
    nxt_st.ld_d = st_ff.ld_s2;
    nxt_st.ext_s1 = ext_scan_clk;
    nxt_st.ext_s2 = st_ff.ext_s1;
    nxt_st.ext_d = st_ff.ext_s2;

    // Shift register, MSB leaves first
    if (sclk_rise) begin
      nxt_st.shreg = {st_ff.shreg[14:0], st_ff.din_s2}; // RULE_01
    end
    // Output taken from the top bit: the first bit in appears
    // half a serial clock after the sixteenth rise
    if (sclk_fall) begin
      nxt_st.dout = st_ff.shreg[15]; // RULE_03 RULE_04 RULE_15
    end

    // Back-pressure visible to the link, registered
    nxt_st.link_rdy = fifo_in_ready;

    // Word dropped when full; set wins over a clear below
    // A lost word is only reported through the overflow flag,
    // so the host has to resend it itself
    if (ld_rise) begin
      if (fifo_in_ready) begin
        nxt_st.words = st_ff.words + 8'h01; // RULE_02
      end
    end

    // Commit sequencer
    case (st_ff.state)
      ST_IDLE: begin
        if (fifo_out_valid) begin
          nxt_st.word = fifo_out_data; // RULE_02
          nxt_st.state = ST_APPLY;
        end
      end
      ST_APPLY: begin
        nxt_st.state = ST_IDLE;
        if (cmd >= `CMD_DIG_FIRST && cmd <= `CMD_DIG_LAST) begin
          // Only the addressed digit changes
          nxt_st.mem[3'(cmd - `CMD_DIG_FIRST)] = st_ff.word[7:0]; // RULE_14
        end else if (cmd == `CMD_DECODE) begin
          nxt_st.decode = st_ff.word[7:0]; // RULE_11
        end else if (cmd == `CMD_LIMIT) begin
          nxt_st.limit = st_ff.word[2:0]; // RULE_12
        end else if (cmd == `CMD_SHUTDOWN) begin
          // Memory untouched, only the output stage is gated
          nxt_st.shutdown = !st_ff.word[0]; // RULE_09
        end else if (cmd == `CMD_SOFT_RST && st_ff.word[0]) begin
          nxt_st.state = ST_CLEAR; // RULE_13
          nxt_st.clr_idx = 3'h0;
        end
      end
      ST_CLEAR: begin
        // One digit a cycle keeps the write port single
        nxt_st.mem[st_ff.clr_idx] = 8'h00; // RULE_13
        nxt_st.clr_idx = st_ff.clr_idx + 3'h1;
        // Decode, limit and shutdown return to their power-up values as well
        nxt_st.decode = `RST_DECODE;
        nxt_st.limit = `RST_LIMIT;
        nxt_st.shutdown = `RST_SHUTDOWN;
        if (st_ff.clr_idx == 3'h7) begin
          nxt_st.state = ST_IDLE;
        end
      end
      default: nxt_st.state = ST_IDLE;
    endcase

    // Scan divider and digit pointer
    // A limit lowered below the pointer wraps it at the next step,
    // so the scan never steps onto a digit beyond the new limit
    if (st_ff.ext_sel || scan_tick) begin
      nxt_st.div = '0;
    end else begin
      nxt_st.div = st_ff.div + 1'b1;
    end
    if (scan_tick) begin
      if (st_ff.idx >= st_ff.limit) begin
        nxt_st.idx = 3'h0; // RULE_12
      end else begin
        nxt_st.idx = st_ff.idx + 3'h1;
      end
    end

    // Output stage refreshed from memory every cycle
    if (st_ff.shutdown) begin
      nxt_st.dig = 8'hff; // RULE_06 RULE_10
      nxt_st.seg = 8'h00; // RULE_07
    end else begin
      nxt_st.dig = ~(8'h01 << st_ff.idx); // RULE_08 RULE_12
      if (st_ff.decode[st_ff.idx]) begin
        nxt_st.seg = font(cur); // RULE_11
      end else begin
        nxt_st.seg = cur; // RULE_11 RULE_07
      end
    end

    // Bus address phase; zero wait states
    // Read data come from the state before this cycle, so a read
    // right after a write to the same register shows the old
    // value; software that needs the new one reads again
    nxt_st.hready = 1'b1;
    nxt_st.hresp = 1'b0; // Never an error response
    nxt_st.a_wr = a_phase && hwrite;
    if (a_phase) begin
      nxt_st.a_addr = haddr[7:0];
      nxt_st.hrdata = rd_mux(haddr[7:0], st_ff);
    end

    // Bus data phase write
    if (st_ff.a_wr && st_ff.a_addr == `REG_CTRL) begin
      nxt_st.ext_sel = hwdata[`CTRL_EXT_SEL]; // RULE_13
      if (hwdata[`CTRL_SOFT_RST]) begin
        nxt_st.state = ST_CLEAR; // RULE_13
        nxt_st.clr_idx = 3'h0;
      end
      if (hwdata[`CTRL_OVF_CLR]) begin
        nxt_st.ovf = 1'b0;
      end
    end

    // Overflow flag, set after the clear so the set wins
    if (ld_rise && !fifo_in_ready) begin
      nxt_st.ovf = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Power-up state is shutdown, so nothing is lit until the
  // host turns the display on
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '0;
      st_ff.state <= ST_IDLE;
      st_ff.decode <= `RST_DECODE;
      st_ff.limit <= `RST_LIMIT;
      st_ff.shutdown <= `RST_SHUTDOWN; // RULE_10
      st_ff.dig <= 8'hff; // RULE_06
      st_ff.link_rdy <= 1'b0;
      st_ff.hready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all straight from flops
  // ---------------------------------------------------------------
  assign serial_data_out = st_ff.dout; // RULE_05
  assign link_ready = st_ff.link_rdy;
  assign digit_drive = st_ff.dig;
  assign segment_drive = st_ff.seg;
  assign hreadyout = st_ff.hready;
  assign hrdata = st_ff.hrdata;
  assign hresp = st_ff.hresp; // Always OKAY, still from a flop

endmodule

`default_nettype wire

// >>> led_front_chk.sv
// Port checker of the LED driver front end
`timescale 1ns/1ps
`default_nettype none

module led_front_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Link pins
  input wire logic serial_clk,
  input wire logic latch_strobe,
  input wire logic serial_data_out,
  input wire logic link_ready,
  // Display
  input wire logic [7:0] digit_drive,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic strobed_ff;
  logic fell_ff;

  // First strobe and first link fall since reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strobed_ff <= 1'b0;
      fell_ff <= 1'b0;
    end else begin
      strobed_ff <= strobed_ff | latch_strobe;
      fell_ff <= fell_ff | $fell(serial_clk);
    end
  end

  sequence clk_high4;
    serial_clk [*4];
  endsequence

  blank_boot_a: assert property (
    !strobed_ff |-> digit_drive == 8'hff)
    else $error("digit lit before any strobe");
  dout_quiet_a: assert property (!fell_ff |-> !serial_data_out)
    else $error("cascade out moved before a link fall");
  dout_edge_a: assert property (
    $changed(serial_data_out) |-> !serial_clk &&
    ($past(serial_clk, 4) || $past(serial_clk, 5) ||
    $past(serial_clk, 6)))
    else $error("cascade out moved away from a link fall");
  dout_hold_a: assert property (clk_high4 |-> $stable(serial_data_out))
    else $error("cascade out moved while link clock high");
  one_digit_a: assert property ($onehot0(~digit_drive))
    else $error("more than one digit lit");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  rdata_hold_a: assert property (
    !$past(hsel && htrans[1] && hready) |-> $stable(hrdata))
    else $error("read data moved without a request");
  fifo_room_a: assert property (!strobed_ff && $past(rst_b) |-> link_ready)
    else $error("no word room before any strobe");
endmodule

`default_nettype wire

// >>> led_host_model.sv
// Host model shifting cascade frames into the LED driver
`timescale 1ns/1ps
`default_nettype none

module led_host_model (
  // Clock
  input wire logic clk,
  // Link pins
  output logic serial_clk,
  output logic serial_data_in,
  output logic latch_strobe,
  input wire logic serial_data_out
);
  logic [31:0] seen_q;

  // Clock stands low between frames
  initial begin
    serial_clk = 1'b0;
    serial_data_in = 1'b0;
    latch_strobe = 1'b0;
    seen_q = 32'h0;
  end

  // Two chained words, MSB first, then one strobe
  task automatic send_frame(input logic [31:0] v);
    for (int i = 31; i >= 0; i--) begin
      serial_data_in <= v[i];
      repeat (8) @(posedge clk);
      serial_clk <= 1'b1;
      seen_q[i] <= serial_data_out;
      repeat (8) @(posedge clk);
      serial_clk <= 1'b0;
    end
    repeat (8) @(posedge clk);
    latch_strobe <= 1'b1;
    serial_data_in <= ~v[0]; // Released line shows no stale bit
    repeat (8) @(posedge clk);
    latch_strobe <= 1'b0;
    repeat (8) @(posedge clk);
  endtask
endmodule

`default_nettype wire

// >>> led_driver_serial_frontend_tb_top.sv
// Testbench of the LED driver front end
`timescale 1ns/1ps
`default_nettype none
`include "led_map.svh"

module led_driver_serial_frontend_tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic serial_clk, serial_data_in, latch_strobe;
  logic serial_data_out, link_ready, hreadyout, hresp;
  logic ext_scan_clk = 1'b0;
  logic ext_run = 1'b0;
  logic [7:0] digit_drive, segment_drive, acc, d8;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic [15:0] prev = 16'h0;
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  // Cycle ceiling and slow external scan clock
  always @(posedge clk) begin
    cycles++;
    if (ext_run && cycles % 8 == 0) ext_scan_clk <= ~ext_scan_clk;
    if (cycles == 30000) begin
      n_errors++;
      give_verdict();
    end
  end

  led_driver_serial_frontend #(.SCAN_DIV(8), .FIFO_DEPTH(16))
    led_driver_serial_frontend_i (.clk(clk), .rst_b(rst_b),
    .serial_clk(serial_clk), .serial_data_in(serial_data_in),
    .latch_strobe(latch_strobe), .serial_data_out(serial_data_out),
    .link_ready(link_ready), .ext_scan_clk(ext_scan_clk),
    .digit_drive(digit_drive), .segment_drive(segment_drive),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp));

  led_host_model led_host_model_i (.clk(clk), .serial_clk(serial_clk),
    .serial_data_in(serial_data_in), .latch_strobe(latch_strobe),
    .serial_data_out(serial_data_out));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    cmp32({24'h0, got}, {24'h0, exp});
  endtask

  // Single word transfer; wait states honoured, read data at 2nd edge
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  // Far word then our word; cascade out must echo 16 bits late
  task automatic frame(input logic [15:0] w);
    @(posedge clk);
    led_host_model_i.send_frame({~w, w});
    cmp32(led_host_model_i.seen_q, {prev, ~w});
    prev = w;
  endtask

  // Segments seen while one digit is scanned
  task automatic seg_at(input logic [7:0] d, input logic [7:0] exp);
    int i;
    i = 0;
    @(negedge clk);
    while (digit_drive !== d && i < 1000) begin
      @(negedge clk);
      i++;
    end
    cmp32({16'h0, digit_drive, segment_drive}, {16'h0, d, exp});
  endtask

  // Union of lit digits over a span
  task automatic sweep(input int n);
    acc = 8'h00;
    repeat (n) begin
      @(negedge clk);
      acc = acc | ~digit_drive;
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    cmp8(digit_drive, 8'hff);
    cmp8({7'h0, link_ready}, 8'h01);
    ahb(1'b0, `REG_STATUS, 32'h0);
    cmp32(rd, 32'h00000701);
    ahb(1'b1, 8'h40, 32'h1);
    ahb(1'b0, 8'h40, 32'h0);
    cmp32(rd, 32'h0);
    $display("test reset done");
    // Raw digits, then one digit rewritten alone
    for (int n = 0; n < 8; n++) begin
      frame({4'h0, 4'(n + 1), 8'(8'h10 + n)});
    end
    frame(16'h037e);
    ahb(1'b0, `REG_DIG_LO, 32'h0);
    cmp32(rd, 32'h137e1110);
    ahb(1'b0, `REG_DIG_HI, 32'h0);
    cmp32(rd, 32'h17161514);
    ahb(1'b0, `REG_STATUS, 32'h0);
    cmp32(rd, 32'h09000701);
    $display("test digits done");
    frame(16'h0c01);
    seg_at(8'hfd, 8'h11);
    seg_at(8'hfb, 8'h7e);
    frame(16'h0901);
    frame(16'h0185);
    seg_at(8'hfe, 8'hdb);
    frame(16'h0b01);
    sweep(100);
    sweep(200);
    cmp8(acc, 8'h03);
    $display("test scan done");
    frame(16'h0c00);
    sweep(200);
    cmp8(acc, 8'h00);
    ahb(1'b0, `REG_DIG_LO, 32'h0);
    cmp32(rd, 32'h137e1185);
    frame(16'h0c01);
    seg_at(8'hfe, 8'hdb);
    $display("test shutdown done");
    // External scan clock: frozen while still, steps when running
    ahb(1'b1, `REG_CTRL, 32'h1);
    ahb(1'b0, `REG_CTRL, 32'h0);
    cmp32(rd, 32'h1);
    sweep(50);
    d8 = digit_drive;
    sweep(200);
    cmp8(acc, ~d8);
    ext_run = 1'b1;
    sweep(300);
    cmp8(acc, 8'h03);
    frame(16'h0f01);
    repeat (20) @(posedge clk);
    ahb(1'b0, `REG_STATUS, 32'h0);
    cmp32(rd & 32'h00ffffff, 32'h00000701);
    ahb(1'b0, `REG_DIG_LO, 32'h0);
    cmp32(rd, 32'h0);
    $display("test reset command done");
    // Bus soft reset, with the overflow clear bit set alongside
    frame(16'h01aa);
    ahb(1'b0, `REG_DIG_LO, 32'h0);
    cmp32(rd, 32'h000000aa);
    ahb(1'b1, `REG_CTRL, 32'h6);
    repeat (20) @(posedge clk);
    ahb(1'b0, `REG_DIG_LO, 32'h0);
    cmp32(rd, 32'h0);
    ahb(1'b0, `REG_CTRL, 32'h0);
    cmp32(rd, 32'h0);
    ahb(1'b0, `REG_STATUS, 32'h0);
    cmp32(rd & 32'h00ffffff, 32'h00000701);
    $display("test bus reset done");
    give_verdict();
  end
endmodule

bind led_driver_serial_frontend led_front_chk led_front_chk_i (
  .clk(clk), .rst_b(rst_b), .serial_clk(serial_clk),
  .latch_strobe(latch_strobe), .serial_data_out(serial_data_out),
  .link_ready(link_ready), .digit_drive(digit_drive), .hsel(hsel),
  .htrans(htrans), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp));

`default_nettype wire
